// *** design/npt_map.svh ***
// Register offsets, reset values and serial frame layout of the preset bank
`ifndef NPT_MAP_SVH
`define NPT_MAP_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define NPT_RDIV_ADDR      15'h0217
`define NPT_FREQ_A_P0      15'h0220
`define NPT_PHASE_A_P0     15'h0224
`define NPT_FREQ_A_P1      15'h0228
`define NPT_PHASE_A_P1     15'h022C
`define NPT_FREQ_A_P2      15'h0230
`define NPT_PHASE_A_P2     15'h0234
`define NPT_FREQ_A_P3      15'h0238
`define NPT_PHASE_A_P3     15'h023C
`define NPT_PRESET_BASE    15'h0220
`define NPT_PRESET_LAST    15'h023F
// ****************************************
// Reset values and field positions
// ****************************************
`define NPT_FREQ_RESET     32'hC0000000
`define NPT_PHASE_RESET    16'h0000
`define NPT_RDIV_RESET     16'h0000
`define NPT_PHASE_LSB      16
// ****************************************
// Serial frame: read flag, 15-bit address, 8-bit data
// ****************************************
`define NPT_SPI_HDR_BITS   5'd16
`define NPT_SPI_FRAME_BITS 5'd24
`endif

// *** design/npt_pkg.sv ***
// Shared types of the oscillator preset bank
package npt_pkg;
  // Register write carried from the serial port
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } npt_wr_type;
  // Active oscillator settings
  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [15:0] rdiv;
  } npt_cfg_type;
  // Serial port frame states
  typedef enum logic [2:0] {
    NPT_IDLE, NPT_HDR, NPT_RLOAD, NPT_RDATA, NPT_WDATA, NPT_DONE
  } npt_spi_state_type;
endpackage : npt_pkg

// *** design/npt_spi_port.sv ***
// Serial control port: frames writes and byte reads for the register bank
`timescale 1ns/1ns
`include "npt_map.svh"
module npt_spi_port
  import npt_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_csn,
  input  wire logic        i_spi_sdi,
  output logic             o_spi_sdo,
  output logic             o_spi_sdo_oe,
  output logic [14:0]      o_rd_addr,
  input  wire logic [7:0]  i_rd_data,
  output npt_wr_type       o_wr,
  output logic             o_wr_valid
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0]        sclk_r;   // Two sync stages plus edge history
  logic [1:0]        csn_r;    // Two sync stages
  logic [1:0]        sdi_r;    // Two sync stages
  logic [23:0]       shift_r;  // Received bits
  logic [7:0]        tx_r;     // Read data to send
  logic [4:0]        cnt_r;    // Bits received
  npt_spi_state_type state_r;  // Frame state
  logic              rise;
  logic              fall;

  // Sync all pins, chip select idles high
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_r <= 3'h0;
      csn_r  <= 2'h3;
      sdi_r  <= 2'h0;
    end else begin
      sclk_r <= {sclk_r[1:0], i_spi_sclk};
      csn_r  <= {csn_r[0], i_spi_csn};
      sdi_r  <= {sdi_r[0], i_spi_sdi};
    end
  end

  // Edges seen only from the second stage onward
  assign rise = sclk_r[1] & ~sclk_r[2];
  assign fall = ~sclk_r[1] & sclk_r[2];

  // ****************************************
  // Frame sequencer
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r    <= NPT_IDLE;
      cnt_r      <= 5'h00;
      shift_r    <= 24'h000000;
      o_rd_addr  <= 15'h0000;
      o_wr       <= '0;
      o_wr_valid <= 1'b0;
    end else begin
      o_wr_valid <= 1'b0;
      if (csn_r[1]) begin
        // Deselect aborts any frame
        state_r <= NPT_IDLE;
        cnt_r   <= 5'h00;
      end else begin
        if (rise) begin
          shift_r <= {shift_r[22:0], sdi_r[1]};
          cnt_r   <= cnt_r + 5'h01;
        end
        case (state_r)
          NPT_IDLE: state_r <= NPT_HDR;
          NPT_HDR: begin
            if (rise && cnt_r == `NPT_SPI_HDR_BITS - 5'h01) begin
              o_rd_addr <= {shift_r[13:0], sdi_r[1]};
              state_r   <= shift_r[14] ? NPT_RLOAD : NPT_WDATA;
            end
          end
          NPT_RLOAD: state_r <= NPT_RDATA;
          NPT_RDATA: begin
            if (rise && cnt_r == `NPT_SPI_FRAME_BITS - 5'h01) begin
              state_r <= NPT_DONE;
            end
          end
          NPT_WDATA: begin
            if (rise && cnt_r == `NPT_SPI_FRAME_BITS - 5'h01) begin
              o_wr       <= '{addr: o_rd_addr, data: {shift_r[6:0], sdi_r[1]}};
              o_wr_valid <= 1'b1;
              state_r    <= NPT_DONE;
            end
          end
          NPT_DONE: state_r <= NPT_DONE;
          default:  state_r <= NPT_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Read data shifter, changes on falling edge
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_r      <= 8'h00;
      o_spi_sdo <= 1'b0;
    end else if (state_r == NPT_RLOAD) begin
      tx_r <= i_rd_data;
    end else if (state_r == NPT_RDATA && fall) begin
      o_spi_sdo <= tx_r[7];
      tx_r      <= {tx_r[6:0], 1'b0};
    end
  end

  // Drive the data pin only while read data is due
  assign o_spi_sdo_oe = (state_r == NPT_RDATA) & ~csn_r[1];
endmodule : npt_spi_port

// *** design/npt_phase_acc.sv ***
// Phase accumulator for channel A, stepped by the sample enable
`timescale 1ns/1ns
`include "npt_map.svh"
module npt_phase_acc
  import npt_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_sample_en,
  input  wire logic        i_sync,
  input  npt_cfg_type      i_cfg,
  output logic [31:0]      o_phase,
  output logic             o_valid
);
  logic [31:0] acc_r;    // Running phase
  logic [32:0] sum;      // Phase plus step, with carry
  logic [31:0] modulus;  // Wrap point when the divisor is on
  logic [31:0] acc_nxt;  // Next phase

  // Step the phase; frequency is word times sample rate over 2^32, or over divisor times 2^16 when the divisor is on
  always_comb begin
    sum     = {1'b0, acc_r} + {1'b0, i_cfg.freq}; // RQ1
    modulus = {i_cfg.rdiv, 16'h0000};
    if (i_cfg.rdiv == `NPT_RDIV_RESET) begin
      acc_nxt = sum[31:0]; // RQ12
    end else if (sum >= {1'b0, modulus}) begin
      acc_nxt = 32'(sum - {1'b0, modulus});
    end else begin
      acc_nxt = sum[31:0];
    end
  end

  // Accumulate on each sample, sync restarts from zero
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_r   <= 32'h00000000;
      o_phase <= 32'h00000000;
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_sample_en;
      if (i_sync) begin
        acc_r <= 32'h00000000; // RQ5
      end else if (i_sample_en) begin
        acc_r <= acc_nxt;
      end
      if (i_sample_en) begin
        // Offset left justified, wraps modulo one turn
        o_phase <= acc_r + {i_cfg.phase, 16'h0000}; // RQ6 RQ7 RQ8
      end
    end
  end
endmodule : npt_phase_acc

// *** design/npt_preset_bank.sv ***
// Oscillator preset bank for channel A with serial register access
//
// Contract
// RQ1 - Output frequency is word times rate over 2^32
// RQ2 - Frequency word treated same signed or unsigned
// RQ3 - Software picks step and divisor for fractions
// RQ4 - Same word meaning for every frequency register
// RQ5 - Word change while running needs re-synchronisation
// RQ6 - Phase word left justified, added to accumulator
// RQ7 - Phase in radians is word/2^16 times 2pi
// RQ8 - Phase word wraps, signed or unsigned alike
// RQ9 - Reset loads default frequency, zero phase
// RQ10 - Preset 1 holds its own frequency word
// RQ11 - Preset 1 holds its own phase word
// RQ12 - Divisor zero gives plain 32-bit accumulator
// RQ13 - One divisor serves all presets
// RQ14 - Preset select picks pair, writes apply next sample
// RQ15 - Reads return last written or reset value
`timescale 1ns/1ns
`include "npt_map.svh"
module npt_preset_bank
  import npt_pkg::*;
#(
  parameter int NUM_PRESETS = 4    // Presets of channel A
)
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_csn,
  input  wire logic        i_spi_sdi,
  output logic             o_spi_sdo,
  output logic             o_spi_sdo_oe,
  input  wire logic [1:0]  i_preset_sel,
  input  wire logic        i_sample_en,
  input  wire logic        i_nco_sync,
  output logic [31:0]      o_nco_phase,
  output logic             o_nco_valid
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] freq_word_a_r  [NUM_PRESETS];  // Frequency words per preset
  logic [15:0] phase_word_a_r [NUM_PRESETS];  // Phase words per preset
  logic [15:0] reference_divisor_r;           // Shared divisor
  logic [1:0]  sel_s1_r;                      // Preset select, first stage
  logic [1:0]  sel_r;                         // Preset select, synchronised
  logic [14:0] rd_addr;                       // Read address from port
  logic [7:0]  rd_data;                       // Read byte to port
  npt_wr_type  wr;                            // Write from port
  logic        wr_valid;                      // Write strobe
  logic        wr_in_bank;                    // Write hits preset window
  logic [1:0]  wr_preset;                     // Preset addressed by write
  logic        wr_is_phase;                   // Write hits a phase word
  logic [1:0]  wr_byte;                       // Byte lane of the write
  npt_cfg_type cfg;                           // Active settings

  // ****************************************
  // Serial control port
  // ****************************************
  npt_spi_port u_spi (
    .i_clock      (i_clock),
    .i_rstn       (i_rstn),
    .i_spi_sclk   (i_spi_sclk),
    .i_spi_csn    (i_spi_csn),
    .i_spi_sdi    (i_spi_sdi),
    .o_spi_sdo    (o_spi_sdo),
    .o_spi_sdo_oe (o_spi_sdo_oe),
    .o_rd_addr    (rd_addr),
    .i_rd_data    (rd_data),
    .o_wr         (wr),
    .o_wr_valid   (wr_valid)
  );

  // ****************************************
  // Write decode
  // ****************************************
  // Each preset takes eight bytes: frequency then phase
  assign wr_in_bank  = wr_valid && wr.addr >= `NPT_PRESET_BASE
                       && wr.addr <= `NPT_PRESET_LAST;
  assign wr_preset   = wr.addr[4:3];
  assign wr_is_phase = wr.addr[2];
  assign wr_byte     = wr.addr[1:0];

  // ****************************************
  // Preset storage, one slice per preset
  // ****************************************
  for (genvar p = 0; p < NUM_PRESETS; p++) begin : g_preset
    // Frequency word, byte writable, raw 32 bits kept
    always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
        freq_word_a_r[p] <= `NPT_FREQ_RESET; // RQ9
      end else if (wr_in_bank && !wr_is_phase && wr_preset == 2'(p)) begin
        // No sign handling: word stored as written
        freq_word_a_r[p][8*wr_byte +: 8] <= wr.data; // RQ2 RQ4 RQ10
      end
    end

    // Phase word, low two bytes only
    always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
        phase_word_a_r[p] <= `NPT_PHASE_RESET; // RQ9
      end else if (wr_in_bank && wr_is_phase && wr_preset == 2'(p)
                   && !wr_byte[1]) begin
        phase_word_a_r[p][8*wr_byte[0] +: 8] <= wr.data; // RQ11
      end
    end
  end

  // ****************************************
  // Shared reference divisor
  // ****************************************
  // One copy for all presets
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      reference_divisor_r <= `NPT_RDIV_RESET;
    end else if (wr_valid && wr.addr == `NPT_RDIV_ADDR) begin
      // Divisor pair sits at an odd base: low byte first
      reference_divisor_r[7:0] <= wr.data; // RQ13
    end else if (wr_valid && wr.addr == `NPT_RDIV_ADDR + 15'h0001) begin
      // High byte at the next address
      reference_divisor_r[15:8] <= wr.data; // RQ13
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Reads show stored words; unmapped bytes read zero
  always_comb begin
    logic [1:0] rp;
    rp      = rd_addr[4:3];
    rd_data = 8'h00;
    if (rd_addr >= `NPT_PRESET_BASE && rd_addr <= `NPT_PRESET_LAST
        && 32'(rp) < NUM_PRESETS) begin
      if (!rd_addr[2]) begin
        rd_data = freq_word_a_r[rp][8*rd_addr[1:0] +: 8]; // RQ15
      end else if (!rd_addr[1]) begin
        rd_data = phase_word_a_r[rp][8*rd_addr[0] +: 8]; // RQ15
      end
    end else if (rd_addr == `NPT_RDIV_ADDR) begin
      rd_data = reference_divisor_r[7:0];
    end else if (rd_addr == `NPT_RDIV_ADDR + 15'h0001) begin
      rd_data = reference_divisor_r[15:8];
    end
  end

  // ****************************************
  // Preset select
  // ****************************************
  // Select comes from a pin: two stages before use
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_s1_r <= 2'h0;
      sel_r    <= 2'h0;
    end else begin
      sel_s1_r <= i_preset_sel;
      sel_r    <= sel_s1_r;
    end
  end

  // Live words feed the accumulator, so writes act next sample
  always_comb begin
    cfg.freq  = freq_word_a_r[sel_r];  // RQ14
    cfg.phase = phase_word_a_r[sel_r]; // RQ14
    cfg.rdiv  = reference_divisor_r;   // RQ13
  end

  // ****************************************
  // Phase accumulator
  // ****************************************
  // Output frequency is word times sample rate over 2^32 with divisor zero, over divisor times 2^16 otherwise;
  // phase offset is word over 2^16 of a full turn.
  // Changing a word while running leaves phase arbitrary;
  // the sync input restarts it.
  npt_phase_acc u_acc (
    .i_clock     (i_clock),
    .i_rstn      (i_rstn),
    .i_sample_en (i_sample_en), // RQ1
    .i_sync      (i_nco_sync),  // RQ5
    .i_cfg       (cfg),         // RQ6 RQ7 RQ8 RQ12
    .o_phase     (o_nco_phase),
    .o_valid     (o_nco_valid)
  );
endmodule : npt_preset_bank

// *** test/npt_preset_bank_monitor.sv ***
// Port checker for the oscillator preset bank
`timescale 1ns/1ns
module npt_preset_bank_monitor
  import npt_pkg::*;
#(
  parameter int NUM_PRESETS = 4    // Presets of channel A
)
(
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_spi_sclk,
  input wire logic        i_spi_csn,
  input wire logic        i_spi_sdi,
  input wire logic        o_spi_sdo,
  input wire logic        o_spi_sdo_oe,
  input wire logic [1:0]  i_preset_sel,
  input wire logic        i_sample_en,
  input wire logic        i_nco_sync,
  input wire logic [31:0] o_nco_phase,
  input wire logic        o_nco_valid
);
  // ****
  // Sequences and checks
  // ****
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Isolated sample pulse
  sequence s_pulse;
    i_sample_en ##1 !i_sample_en;
  endsequence
  // Select released long enough to settle
  sequence s_bus_idle;
    i_spi_csn [*4];
  endsequence
  a_valid_follows: assert property (i_sample_en |=> o_nco_valid)
    else $error("valid missing after sample");
  a_valid_single: assert property (s_pulse |=> !o_nco_valid)
    else $error("valid longer than one cycle");
  a_valid_cause: assert property (o_nco_valid |-> $past(i_sample_en))
    else $error("valid without sample");
  a_phase_hold: assert property (!i_sample_en |=> $stable(o_nco_phase))
    else $error("phase moved without sample");
  a_reset_clear: assert property ($rose(i_rstn) |-> o_nco_phase == 32'h0)
    else $error("phase not clear after reset");
  a_oe_idle: assert property (s_bus_idle |-> !o_spi_sdo_oe)
    else $error("data out driven while idle");
  a_oe_select: assert property (o_spi_sdo_oe |-> !$past(i_spi_csn, 5))
    else $error("data out driven without select");
  a_oe_release: assert property ($rose(i_spi_csn) |-> ##[1:5] !o_spi_sdo_oe)
    else $error("data out kept after deselect");
endmodule : npt_preset_bank_monitor

bind npt_preset_bank npt_preset_bank_monitor #(.NUM_PRESETS(NUM_PRESETS)) u_monitor (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_spi_sclk(i_spi_sclk), .i_spi_csn(i_spi_csn),
  .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe(o_spi_sdo_oe),
  .i_preset_sel(i_preset_sel), .i_sample_en(i_sample_en), .i_nco_sync(i_nco_sync),
  .o_nco_phase(o_nco_phase), .o_nco_valid(o_nco_valid));

// *** test/test_nco_preset_tuning_regs.sv ***
// Self-checking bench for the oscillator preset bank
`timescale 1ns/1ns
`include "npt_map.svh"
module test_nco_preset_tuning_regs;
  logic        i_clock;          // System clock
  logic        i_rstn;           // Reset, active low
  logic        i_spi_sclk;       // Serial clock
  logic        i_spi_csn;        // Serial select, active low
  logic        i_spi_sdi;        // Serial data in
  logic        o_spi_sdo;        // Serial data out
  logic        o_spi_sdo_oe;     // Data out enable
  logic [1:0]  i_preset_sel;     // Active preset
  logic        i_sample_en;      // Sample pulse
  logic        i_nco_sync;       // Accumulator clear
  logic [31:0] o_nco_phase;      // Phase output
  logic        o_nco_valid;      // Phase valid
  logic        oe_all;           // Enable seen on every data bit
  logic [7:0]  rd_byte;          // Last byte read
  int          miscompares = 0;  // Mismatch count
  int          comparisons = 0;  // Compare count
  int          cycles = 0;       // Timeout counter

  npt_preset_bank #(.NUM_PRESETS(4)) u_dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_spi_sclk(i_spi_sclk), .i_spi_csn(i_spi_csn),
    .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe(o_spi_sdo_oe),
    .i_preset_sel(i_preset_sel), .i_sample_en(i_sample_en), .i_nco_sync(i_nco_sync),
    .o_nco_phase(o_nco_phase), .o_nco_valid(o_nco_valid));

  // Free-running clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Cut a hang short
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One 24-bit frame, sclk half period 5 clocks
  task automatic spi_frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd);
    logic [23:0] frame;
    frame = {rd, addr, wd};
    oe_all = 1'b1;
    i_spi_csn <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      i_spi_sdi <= frame[i];
      repeat (5) @(posedge i_clock);
      if (i < 8) begin
        rd_byte[i] = o_spi_sdo;
        oe_all = oe_all & o_spi_sdo_oe;
      end
      i_spi_sclk <= 1'b1;
      repeat (5) @(posedge i_clock);
      i_spi_sclk <= 1'b0;
    end
    repeat (5) @(posedge i_clock);
    i_spi_csn <= 1'b1;
    repeat (6) @(posedge i_clock);
  endtask : spi_frame
  // Read one byte and compare
  task automatic rd_check(input logic [14:0] addr, input logic [7:0] exp);
    spi_frame(1'b1, addr, 8'h00);
    check("spi read", {24'h0, rd_byte}, {24'h0, exp});
    check("read enable", {31'h0, oe_all}, 32'h1);
  endtask : rd_check
  // Little endian multi-byte access
  task automatic wr32(input logic [14:0] a, input logic [31:0] v);
    for (int b = 0; b < 4; b++) spi_frame(1'b0, a + 15'(b), v[8*b +: 8]);
  endtask : wr32
  task automatic wr16(input logic [14:0] a, input logic [15:0] v);
    for (int b = 0; b < 2; b++) spi_frame(1'b0, a + 15'(b), v[8*b +: 8]);
  endtask : wr16
  task automatic rd32(input logic [14:0] a, input logic [31:0] v);
    for (int b = 0; b < 4; b++) rd_check(a + 15'(b), v[8*b +: 8]);
  endtask : rd32
  task automatic rd16(input logic [14:0] a, input logic [15:0] v);
    for (int b = 0; b < 2; b++) rd_check(a + 15'(b), v[8*b +: 8]);
  endtask : rd16
  // One sample pulse, then judge the output
  task automatic sample(input logic [31:0] exp);
    i_sample_en <= 1'b1;
    @(posedge i_clock);
    i_sample_en <= 1'b0;
    @(negedge i_clock);
    check("valid", {31'h0, o_nco_valid}, 32'h1);
    check("phase", o_nco_phase, exp);
    @(posedge i_clock);
  endtask : sample
  // Clear the accumulator
  task automatic sync_acc();
    i_nco_sync <= 1'b1;
    @(posedge i_clock);
    i_nco_sync <= 1'b0;
    @(posedge i_clock);
  endtask : sync_acc
  // ****
  // Scenarios
  // ****
  task automatic test_reset_values();
    rd32(`NPT_FREQ_A_P0, 32'hC0000000);
    rd16(`NPT_PHASE_A_P0, 16'h0000);
    rd32(`NPT_FREQ_A_P2, 32'hC0000000);
    rd_check(`NPT_RDIV_ADDR, 8'h00);
  endtask : test_reset_values
  task automatic test_preset1();
    wr32(`NPT_FREQ_A_P1, 32'h12345678);
    wr16(`NPT_PHASE_A_P1, 16'hC000);
    rd32(`NPT_FREQ_A_P1, 32'h12345678);
    rd16(`NPT_PHASE_A_P1, 16'hC000);
    rd_check(`NPT_FREQ_A_P0 + 15'd3, 8'hC0);
  endtask : test_preset1
  task automatic test_unmapped();
    spi_frame(1'b0, `NPT_PHASE_A_P0 + 15'd2, 8'hFF);
    rd_check(`NPT_PHASE_A_P0 + 15'd2, 8'h00);
  endtask : test_unmapped
  task automatic test_accum();
    i_preset_sel <= 2'd0;
    repeat (4) @(posedge i_clock);
    sync_acc();
    sample(32'h00000000);
    sample(32'hC0000000);
    sample(32'h80000000);
    sample(32'h40000000);
    i_preset_sel <= 2'd1;
    repeat (4) @(posedge i_clock);
    sync_acc();
    sample(32'hC0000000);
    sample(32'hD2345678);
    sample(32'hE468ACF0);
    spi_frame(1'b0, `NPT_PHASE_A_P1 + 15'd1, 8'h40);
    sample(32'h769D0368);
  endtask : test_accum
  // Shared divisor wraps two presets alike
  task automatic test_divisor();
    wr16(`NPT_RDIV_ADDR, 16'h1235);
    spi_frame(1'b0, `NPT_FREQ_A_P2 + 15'd3, 8'h10);
    rd16(`NPT_RDIV_ADDR, 16'h1235);
    i_preset_sel <= 2'd2;
    repeat (4) @(posedge i_clock);
    sync_acc();
    sample(32'h00000000);
    sample(32'h10000000);
    sample(32'h0DCB0000);
    i_preset_sel <= 2'd1;
    repeat (4) @(posedge i_clock);
    sync_acc();
    sample(32'h40000000);
    sample(32'h52345678);
    sample(32'h5233ACF0);
  endtask : test_divisor
  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    i_rstn = 1'b0;
    i_spi_sclk = 1'b0;
    i_spi_csn = 1'b1;
    i_spi_sdi = 1'b0;
    i_preset_sel = 2'd0;
    i_sample_en = 1'b0;
    i_nco_sync = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clock);
    test_reset_values();
    test_preset1();
    test_unmapped();
    test_accum();
    test_divisor();
    stop_test();
  end
endmodule : test_nco_preset_tuning_regs
